/* logic/mlt_lookup.sv */
// MAC address lookup table with per-port lookup controls and host access
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Null-VID bit set: VID zero looked up as zero, else default VID used.
// - Ingress filtering set: drop frames whose VLAN excludes the ingress port.
// - Non-default-VID discard set: drop frames whose VID differs from default VID.
// - Control bit 4 enables MAC-based authentication in the lookup engine.
// - Port and global self-filter set: drop frames sourced from switch MAC.
// - Three-bit pointer selects which of eight instances the state register reaches.
// - Per instance: transmit bit 2, receive bit 1 reset one; learn-disable bit 0.
// - Destination lookups search all tables; source lookups learn in this table.
// - Static destination hit overrides any dynamic hit.
// - Four-way table, 1K buckets, 4K entries, 10-bit hashed bucket index.
// - Place in bucket with free way, else replace least recently used dynamic.
// - Static add to bucket with 2 or 3 statics flags almost-full, address saved.
// - Static write into four-static bucket fails, flags, bucket index saved.
// - Four-static bucket refuses learning, flags learn-fail, index saved.
// - Host reads any entry but writes only static entries.
// - Host access by hash, by direct address, or by sequential search.
// - Device clears go bit when done; then valid tells whether found.
// - One status bit combines go/done and valid for in-band polling.
// - No valid entry returned: all four entry registers read zero.
// - Entry bit 31 marks static entries, never aged; dynamic ones learned.
module mlt_lookup (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic hash_use_group,
  input wire logic self_filt_en,
  input wire logic [47:0] switch_mac,
  input wire logic fr_req,
  output logic fr_ready,
  input wire logic [2:0] fr_port,
  input wire logic [47:0] fr_sa,
  input wire logic [47:0] fr_da,
  input wire logic [6:0] fr_filter_group_id,
  input wire logic fr_tagged,
  input wire logic [11:0] fr_vid,
  input wire logic [11:0] fr_port_default_vlan_id,
  input wire logic [2:0] fr_mstp,
  input wire logic [5:0] fr_vlan_member,
  input wire logic st_hit,
  input wire logic [5:0] st_ports,
  output logic [11:0] fr_lookup_vid,
  output logic fr_done,
  output logic fr_drop,
  output logic [5:0] fr_ports,
  output logic fr_auth_en,
  output logic irq_almost_full,
  output logic irq_write_fail,
  output logic irq_learn_fail
);
  typedef struct packed {
    mlt_pkg::mlt_state_t fsm;
    logic [5:0][7:0] pctl;
    logic [5:0][7:0] ptr;
    logic [5:0][7:0][2:0] mst;
    logic [54:0] key;
    logic go;
    logic valid;
    logic direct;
    logic [1:0] action;
    logic [127:0] ent;
    logic [11:0] eidx0;
    logic [9:0] eidx1;
    logic [11:0] cnt;
    logic [9:0] bkt;
    logic [1:0] way;
    logic hit;
    logic [1:0] hit_way;
    logic [127:0] hit_ent;
    logic free_ok;
    logic [1:0] free_way;
    logic dyn_ok;
    logic [1:0] dyn_way;
    logic [2:0] dyn_age;
    logic [2:0] nstat;
    logic [2:0] f_port;
    logic [2:0] f_mstp;
    logic [47:0] f_sa;
    logic [47:0] f_da;
    logic [6:0] f_group;
    logic [7:0] f_ctl;
    logic [2:0] f_st;
    logic [5:0] f_tx;
    logic f_pre_drop;
    logic [11:0] lkvid;
    logic done;
    logic drop;
    logic [5:0] ports;
    logic auth;
    logic i_af;
    logic i_wf;
    logic i_lf;
    logic [31:0] rdata;
  } mlt_regs_t;

  mlt_regs_t q, n;
  logic [127:0] mem [4096];
  logic [127:0] mem_rd;
  logic [11:0] rd_addr;
  logic mem_we;
  logic [11:0] mem_wa;
  logic [127:0] mem_wd;
  logic [3:0] pnum;
  logic psel;
  logic [2:0] pi;

  // Bucket hash: XOR fold of the address, filter group mixed in on request
  function automatic logic [9:0] hash10(input logic [47:0] mac, input logic [6:0] grp,
                                        input logic use_grp);
    hash10 = mac[9:0] ^ mac[19:10] ^ mac[29:20] ^ mac[39:30] ^ {2'h0, mac[47:40]}
           ^ (use_grp ? {3'h0, grp} : 10'h000);
  endfunction

  // Static entries always live; dynamic ones while the age count is nonzero
  function automatic logic ent_valid(input logic [127:0] e);
    ent_valid = e[mlt_pkg::E_STATIC] || (e[mlt_pkg::E_AGE_LO +: 3] != 3'h0);
  endfunction

  // Fresh dynamic entry for a learned source address
  function automatic logic [127:0] new_dyn(input logic [47:0] mac, input logic [6:0] grp,
                                           input logic [2:0] inst, input logic [2:0] port);
    new_dyn = '0;
    new_dyn[mlt_pkg::E_AGE_LO +: 3] = mlt_pkg::AGE_RELOAD;
    new_dyn[98:96] = inst;
    new_dyn[mlt_pkg::E_PORT_LO +: 6] = 6'(6'h01 << port);
    new_dyn[54:0] = {grp, mac};
  endfunction

  assign rd_addr = (q.fsm == mlt_pkg::S_SRCH) ? q.cnt : {q.bkt, q.way};
  assign mem_rd = mem[rd_addr];
  assign pnum = reg_addr[15:12];
  assign psel = (pnum >= 4'h1) && (pnum <= 4'h6);
  assign pi = 3'(pnum - 4'h1);

  // Table storage, cleared by the init sweep after reset
  always_ff @(posedge clk) begin
    if (ce && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Next-state logic for engine, host access and registers
  always_comb begin
    logic [54:0] cmp;
    logic [127:0] e;
    logic [1:0] tgt;
    n = q;
    cmp = (q.fsm == mlt_pkg::S_SA) ? {q.f_group, q.f_sa} :
          (q.fsm == mlt_pkg::S_DA) ? {q.f_group, q.f_da} : q.key;
    e = '0;
    tgt = 2'h0;
    mem_we = 1'b0;
    mem_wa = {q.bkt, q.way};
    mem_wd = '0;
    n.done = 1'b0;
    n.i_af = 1'b0;
    n.i_wf = 1'b0;
    n.i_lf = 1'b0;
    case (q.fsm)
      mlt_pkg::S_INIT: begin
        mem_we = 1'b1;
        mem_wa = q.cnt;
        n.cnt = q.cnt + 12'h001;
        if (q.cnt == mlt_pkg::IDX_MAX) begin
          n.fsm = mlt_pkg::S_IDLE;
        end
      end
      mlt_pkg::S_IDLE: begin
        n.hit = 1'b0;
        n.free_ok = 1'b0;
        n.dyn_ok = 1'b0;
        n.nstat = 3'h0;
        n.way = 2'h0;
        if (fr_req) begin
          // Snapshot controls so a later write cannot change this frame
          n.f_port = fr_port;
          n.f_mstp = fr_mstp;
          n.f_sa = fr_sa;
          n.f_da = fr_da;
          n.f_group = fr_filter_group_id;
          n.f_ctl = q.pctl[fr_port];
          n.f_st = q.mst[fr_port][fr_mstp];
          for (int p = 0; p < mlt_pkg::PORTS; p++) begin
            n.f_tx[p] = q.mst[p][fr_mstp][mlt_pkg::ST_TX];
          end
          n.lkvid = (!fr_tagged || (fr_vid == 12'h000 && !q.pctl[fr_port][mlt_pkg::CTL_NULL_VID]))
                  ? fr_port_default_vlan_id : fr_vid;
          n.f_pre_drop = (q.pctl[fr_port][mlt_pkg::CTL_NON_DEF_VID] && fr_tagged
                          && fr_vid != fr_port_default_vlan_id)
                       || (q.pctl[fr_port][mlt_pkg::CTL_SELF] && self_filt_en
                          && fr_sa == switch_mac);
          n.bkt = hash10(fr_sa, fr_filter_group_id, hash_use_group);
          n.fsm = mlt_pkg::S_SA;
        end else if (q.go) begin
          // Host operations wait for the frame engine to be idle
          if (q.action == mlt_pkg::ACT_SEARCH) begin
            n.cnt = 12'h000;
            n.valid = 1'b0;
            n.fsm = mlt_pkg::S_SRCH;
          end else if (q.action == mlt_pkg::ACT_NONE) begin
            n.go = 1'b0;
          end else if (q.direct) begin
            n.bkt = q.key[11:2];
            n.way = q.key[1:0];
            n.fsm = mlt_pkg::S_HEND;
          end else begin
            n.bkt = hash10(q.key[47:0], q.key[54:48], hash_use_group);
            n.fsm = mlt_pkg::S_HSCAN;
          end
        end
      end
      mlt_pkg::S_SA, mlt_pkg::S_DA, mlt_pkg::S_HSCAN: begin
        // One way per cycle: match, free way, oldest dynamic, static count
        if (ent_valid(mem_rd)) begin
          if (mem_rd[mlt_pkg::E_STATIC]) begin
            n.nstat = q.nstat + 3'h1;
          end else if (!q.dyn_ok || mem_rd[mlt_pkg::E_AGE_LO +: 3] < q.dyn_age) begin
            n.dyn_ok = 1'b1;
            n.dyn_way = q.way;
            n.dyn_age = mem_rd[mlt_pkg::E_AGE_LO +: 3];
          end
          if (mem_rd[54:0] == cmp) begin
            n.hit = 1'b1;
            n.hit_way = q.way;
            n.hit_ent = mem_rd;
          end
        end else if (!q.free_ok) begin
          n.free_ok = 1'b1;
          n.free_way = q.way;
        end
        n.way = q.way + 2'h1;
        if (q.way == 2'h3) begin
          n.fsm = (q.fsm == mlt_pkg::S_SA) ? mlt_pkg::S_SAL :
                  (q.fsm == mlt_pkg::S_DA) ? mlt_pkg::S_FIN : mlt_pkg::S_HEND;
        end
      end
      mlt_pkg::S_SAL: begin
        // Source side: refresh, migrate or learn, in this table only
        mem_wd = new_dyn(q.f_sa, q.f_group, q.f_mstp, q.f_port);
        if (q.hit) begin
          mem_wa = {q.bkt, q.hit_way};
          mem_we = !q.hit_ent[mlt_pkg::E_STATIC];
        end else if (!q.f_st[mlt_pkg::ST_NOLRN] && q.f_st[mlt_pkg::ST_RX]) begin
          if (q.free_ok || q.dyn_ok) begin
            mem_we = 1'b1;
            mem_wa = {q.bkt, q.free_ok ? q.free_way : q.dyn_way};
          end else begin
            n.i_lf = 1'b1;
            n.eidx1 = q.bkt;
          end
        end
        n.hit = 1'b0;
        n.free_ok = 1'b0;
        n.dyn_ok = 1'b0;
        n.nstat = 3'h0;
        n.way = 2'h0;
        n.bkt = hash10(q.f_da, q.f_group, hash_use_group);
        n.fsm = mlt_pkg::S_DA;
      end
      mlt_pkg::S_FIN: begin
        n.drop = q.f_pre_drop || !q.f_st[mlt_pkg::ST_RX]
               || (q.f_ctl[mlt_pkg::CTL_INGR_FILT] && !fr_vlan_member[q.f_port])
               || (q.hit && q.hit_ent[mlt_pkg::E_DSTF]);
        // Static table result first, then this table, else flood
        n.ports = (st_hit ? st_ports : q.hit ? q.hit_ent[mlt_pkg::E_PORT_LO +: 6] : 6'h3F)
                & q.f_tx & ~6'(6'h01 << q.f_port);
        n.auth = q.f_ctl[mlt_pkg::CTL_AUTH];
        n.done = 1'b1;
        n.fsm = mlt_pkg::S_IDLE;
      end
      mlt_pkg::S_HEND: begin
        if (q.action == mlt_pkg::ACT_READ) begin
          e = q.direct ? mem_rd : (q.hit ? q.hit_ent : '0);
          n.valid = ent_valid(e);
          n.ent = ent_valid(e) ? e : '0;
        end else begin
          // Host writes always produce static entries
          mem_wd = {1'b1, q.ent[126:0]};
          if (q.direct || q.hit) begin
            mem_we = 1'b1;
            mem_wa = q.direct ? {q.bkt, q.way} : {q.bkt, q.hit_way};
          end else if (q.nstat == mlt_pkg::BUCKET_FULL) begin
            n.i_wf = 1'b1;
            n.eidx0 = {2'h0, q.bkt};
          end else begin
            tgt = q.free_ok ? q.free_way : q.dyn_way;
            mem_we = 1'b1;
            mem_wa = {q.bkt, tgt};
            if (q.nstat >= mlt_pkg::ALMOST_FULL_MIN) begin
              n.i_af = 1'b1;
              n.eidx0 = {q.bkt, tgt};
            end
          end
        end
        n.go = 1'b0;
        n.fsm = mlt_pkg::S_IDLE;
      end
      mlt_pkg::S_SRCH: begin
        if (!q.go) begin
          n.fsm = mlt_pkg::S_IDLE;
        end else if (ent_valid(mem_rd)) begin
          n.ent = mem_rd;
          n.valid = 1'b1;
          n.fsm = mlt_pkg::S_SWAIT;
        end else if (q.cnt == mlt_pkg::IDX_MAX) begin
          n.go = 1'b0;
          n.ent = '0;
          n.fsm = mlt_pkg::S_IDLE;
        end else begin
          n.cnt = q.cnt + 12'h001;
        end
      end
      mlt_pkg::S_SWAIT: begin
        // Reading the last entry word lets the search move on
        if (!q.go) begin
          n.fsm = mlt_pkg::S_IDLE;
        end else if (reg_rd && reg_addr == mlt_pkg::ENT4_OFS) begin
          n.valid = 1'b0;
          if (q.cnt == mlt_pkg::IDX_MAX) begin
            n.go = 1'b0;
            n.ent = '0;
            n.fsm = mlt_pkg::S_IDLE;
          end else begin
            n.cnt = q.cnt + 12'h001;
            n.fsm = mlt_pkg::S_SRCH;
          end
        end
      end
      default: begin
        n.fsm = mlt_pkg::S_IDLE;
      end
    endcase
    // Register writes; while busy the access register takes only a go clear, which stops a search
    if (reg_wr) begin
      if (psel && reg_addr[11:0] == mlt_pkg::PORT_CTL_OFS) begin
        n.pctl[pi] = reg_wdata[7:0] & mlt_pkg::CTL_WR_MASK;
      end
      if (psel && reg_addr[11:0] == mlt_pkg::PORT_PTR_OFS) begin
        n.ptr[pi] = reg_wdata[7:0];
      end
      if (psel && reg_addr[11:0] == mlt_pkg::PORT_ST_OFS) begin
        n.mst[pi][q.ptr[pi][2:0]] = reg_wdata[2:0];
      end
      case (reg_addr)
        mlt_pkg::KEY_HI_OFS: n.key[54:32] = reg_wdata[22:0];
        mlt_pkg::KEY_LO_OFS: n.key[31:0] = reg_wdata;
        mlt_pkg::ENT1_OFS: n.ent[127:96] = reg_wdata;
        mlt_pkg::ENT2_OFS: n.ent[95:64] = reg_wdata;
        mlt_pkg::ENT3_OFS: n.ent[63:32] = reg_wdata;
        mlt_pkg::ENT4_OFS: n.ent[31:0] = reg_wdata;
        mlt_pkg::ACC_OFS: begin
          if (q.fsm == mlt_pkg::S_IDLE && !fr_req) begin
            n.go = reg_wdata[mlt_pkg::AC_GO];
            n.direct = reg_wdata[mlt_pkg::AC_DIRECT];
            n.action = reg_wdata[1:0];
          end else if (!reg_wdata[mlt_pkg::AC_GO]) begin
            n.go = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Register reads, answered one cycle later; unmapped reads give zero
    if (reg_rd) begin
      n.rdata = 32'h0000_0000;
      if (psel && reg_addr[11:0] == mlt_pkg::PORT_CTL_OFS) begin
        n.rdata[7:0] = q.pctl[pi];
      end
      if (psel && reg_addr[11:0] == mlt_pkg::PORT_PTR_OFS) begin
        n.rdata[7:0] = q.ptr[pi];
      end
      if (psel && reg_addr[11:0] == mlt_pkg::PORT_ST_OFS) begin
        n.rdata[2:0] = q.mst[pi][q.ptr[pi][2:0]];
      end
      case (reg_addr)
        mlt_pkg::EIDX0_OFS: n.rdata[11:0] = q.eidx0;
        mlt_pkg::EIDX1_OFS: n.rdata[9:0] = q.eidx1;
        mlt_pkg::KEY_HI_OFS: n.rdata[22:0] = q.key[54:32];
        mlt_pkg::KEY_LO_OFS: n.rdata = q.key[31:0];
        mlt_pkg::ENT1_OFS: n.rdata = q.ent[127:96];
        mlt_pkg::ENT2_OFS: n.rdata = q.ent[95:64];
        mlt_pkg::ENT3_OFS: n.rdata = q.ent[63:32];
        mlt_pkg::ENT4_OFS: n.rdata = q.ent[31:0];
        mlt_pkg::ACC_OFS: begin
          n.rdata[mlt_pkg::AC_GO] = q.go;
          n.rdata[mlt_pkg::AC_VALID] = q.valid;
          n.rdata[mlt_pkg::AC_VES] = !q.go || q.valid;
          n.rdata[mlt_pkg::AC_DIRECT] = q.direct;
          n.rdata[1:0] = q.action;
        end
        default: begin
        end
      endcase
    end
  end

  // State register; all state holds while the clock enable is low
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.fsm <= mlt_pkg::S_INIT;
      for (int p = 0; p < mlt_pkg::PORTS; p++) begin
        q.pctl[p] <= mlt_pkg::CTL_RST;
        q.ptr[p] <= mlt_pkg::PTR_RST;
        for (int s = 0; s < 8; s++) begin
          q.mst[p][s] <= mlt_pkg::ST_RST;
        end
      end
    end else if (ce) begin
      q <= n;
    end
  end

  assign fr_ready = (q.fsm == mlt_pkg::S_IDLE);
  assign reg_rdata = q.rdata;
  assign fr_lookup_vid = q.lkvid;
  assign fr_done = q.done;
  assign fr_drop = q.drop;
  assign fr_ports = q.ports;
  assign fr_auth_en = q.auth;
  assign irq_almost_full = q.i_af;
  assign irq_write_fail = q.i_wf;
  assign irq_learn_fail = q.i_lf;

  // Checks below assume the clock enable is held high
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_go_cleared: assert property (ce && q.fsm == mlt_pkg::S_HEND |=> !q.go)
    else $error("go bit not cleared after operation");
  a_ves_status: assert property (ce && reg_rd && reg_addr == mlt_pkg::ACC_OFS
      |=> reg_rdata[mlt_pkg::AC_VES] == (!$past(q.go) || $past(q.valid)))
    else $error("combined status bit wrong");
  a_read_zero: assert property (ce && q.fsm == mlt_pkg::S_HEND && q.action == mlt_pkg::ACT_READ
      |=> q.valid || q.ent == '0)
    else $error("entry not zero on miss");
  a_learn_idx: assert property (irq_learn_fail |-> q.eidx1 == $past(q.bkt))
    else $error("learn fail index wrong");
  a_wfail_idx: assert property (irq_write_fail |-> q.eidx0 == {2'h0, $past(q.bkt)})
    else $error("write fail index wrong");
  a_afull_idx: assert property (irq_almost_full |-> q.eidx0[11:2] == $past(q.bkt))
    else $error("almost full address wrong");
  a_self_drop: assert property (ce && fr_req && fr_ready && self_filt_en && fr_sa == switch_mac
      && q.pctl[fr_port][mlt_pkg::CTL_SELF] |-> ##11 (fr_done && fr_drop))
    else $error("own source address not dropped");
  a_defvid_drop: assert property (ce && fr_req && fr_ready && fr_tagged
      && q.pctl[fr_port][mlt_pkg::CTL_NON_DEF_VID] && fr_vid != fr_port_default_vlan_id
      |-> ##11 (fr_done && fr_drop))
    else $error("non default VID not dropped");
  a_tx_gate: assert property (fr_done |-> (fr_ports & ~q.f_tx) == 6'h00)
    else $error("forward to transmit-disabled port");
  a_static_wr: assert property (mem_we && q.fsm == mlt_pkg::S_HEND
      |-> mem_wd[mlt_pkg::E_STATIC])
    else $error("host wrote a dynamic entry");
endmodule
`default_nettype wire

/* logic/mlt_pkg.sv */
// Constants, register map and state encoding of the MAC address lookup table
package mlt_pkg;
  localparam int PORTS = 6;
  localparam int IDX_W = 12;
  localparam int BKT_W = 10;
  localparam logic [11:0] IDX_MAX = 12'hFFF;
  // Per-port registers: port number in address bits 15:12, sub-address below
  localparam logic [11:0] PORT_CTL_OFS = 12'hB00;
  localparam logic [11:0] PORT_PTR_OFS = 12'hB01;
  localparam logic [11:0] PORT_ST_OFS = 12'hB04;
  // Table access registers
  localparam logic [15:0] EIDX0_OFS = 16'h0408;
  localparam logic [15:0] EIDX1_OFS = 16'h040C;
  localparam logic [15:0] KEY_HI_OFS = 16'h0410;
  localparam logic [15:0] KEY_LO_OFS = 16'h0414;
  localparam logic [15:0] ACC_OFS = 16'h0418;
  localparam logic [15:0] ENT1_OFS = 16'h0420;
  localparam logic [15:0] ENT2_OFS = 16'h0424;
  localparam logic [15:0] ENT3_OFS = 16'h0428;
  localparam logic [15:0] ENT4_OFS = 16'h042C;
  // Port lookup control fields
  localparam int CTL_NULL_VID = 7;
  localparam int CTL_INGR_FILT = 6;
  localparam int CTL_NON_DEF_VID = 5;
  localparam int CTL_AUTH = 4;
  localparam int CTL_SELF = 3;
  localparam logic [7:0] CTL_WR_MASK = 8'hFA;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  // Spanning-tree state fields
  localparam int ST_TX = 2;
  localparam int ST_RX = 1;
  localparam int ST_NOLRN = 0;
  localparam logic [2:0] ST_RST = 3'h6;
  // Access control fields
  localparam int AC_GO = 7;
  localparam int AC_VALID = 6;
  localparam int AC_VES = 5;
  localparam int AC_DIRECT = 2;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_WRITE = 2'h1;
  localparam logic [1:0] ACT_READ = 2'h2;
  localparam logic [1:0] ACT_SEARCH = 2'h3;
  // Entry layout inside the 128-bit word (entry 1 word on top)
  localparam int E_STATIC = 127;
  localparam int E_DSTF = 125;
  localparam int E_AGE_LO = 122;
  localparam int E_PORT_LO = 64;
  localparam logic [2:0] AGE_RELOAD = 3'h7;
  localparam logic [2:0] ALMOST_FULL_MIN = 3'h2;
  localparam logic [2:0] BUCKET_FULL = 3'h4;

  typedef enum logic [3:0] {
    S_INIT, S_IDLE, S_SA, S_SAL, S_DA, S_FIN, S_HSCAN, S_HEND, S_SRCH, S_SWAIT
  } mlt_state_t;
endpackage

/* verif/mlt_far_model.sv */
// Far-side model of the VLAN table and static address table
`timescale 1ns/100ps
`default_nettype none
module mlt_far_model (
  input wire logic [11:0] vid,
  input wire logic [47:0] da,
  output logic [5:0] member,
  output logic st_hit,
  output logic [5:0] st_ports
);
  // VID 5 leaves port 1 out, so ingress filtering has a victim
  assign member = (vid == 12'h005) ? 6'h3E : 6'h3F;
  // One static destination; a miss shows junk ports, never the hit value
  assign st_hit = (da == 48'h0200_0000_0BAD);
  assign st_ports = st_hit ? 6'h0C : 6'h15;
endmodule
`default_nettype wire

/* verif/tb_mlt_lookup.sv */
// Self-checking bench for the MAC address lookup table
`timescale 1ns/100ps
`default_nettype none
module tb_mlt_lookup;
  localparam logic [15:0] P_CTL = {4'h1, mlt_pkg::PORT_CTL_OFS};
  localparam logic [15:0] P_PTR = {4'h1, mlt_pkg::PORT_PTR_OFS};
  localparam logic [15:0] P_ST = {4'h1, mlt_pkg::PORT_ST_OFS};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic self_filt_en = 1'b0;
  logic hash_use_group = 1'b0;
  logic [2:0] irq_seen = 3'h0;
  logic [47:0] switch_mac = 48'h0200_0000_5E1F;
  logic fr_req = 1'b0;
  logic fr_tagged = 1'b0;
  logic [2:0] fr_port = 3'h0;
  logic [11:0] fr_vid = 12'h0;
  logic [47:0] fr_sa = 48'h0;
  logic [47:0] fr_da = 48'h0200_0000_0001;
  logic [31:0] reg_rdata, rv;
  logic fr_ready, fr_done, fr_drop, fr_auth_en, st_hit;
  logic irq_almost_full, irq_write_fail, irq_learn_fail;
  logic [11:0] fr_lookup_vid;
  logic [5:0] fr_ports, member, st_ports;
  int bad_count = 0;
  int n_checks = 0;

  // Free-running core clock
  always #5 clk = ~clk;

  // Sticky record of interrupt pulses, since they stand for one cycle only
  always @(posedge clk) begin
    if (!rst) begin
      irq_seen <= irq_seen | {irq_learn_fail, irq_write_fail, irq_almost_full};
    end
  end

  mlt_lookup dut_u (.clk(clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .hash_use_group(hash_use_group),
    .self_filt_en(self_filt_en), .switch_mac(switch_mac), .fr_req(fr_req),
    .fr_ready(fr_ready), .fr_port(fr_port), .fr_sa(fr_sa), .fr_da(fr_da),
    .fr_filter_group_id(7'h01), .fr_tagged(fr_tagged), .fr_vid(fr_vid),
    .fr_port_default_vlan_id(12'h00A), .fr_mstp(3'h0), .fr_vlan_member(member),
    .st_hit(st_hit), .st_ports(st_ports), .fr_lookup_vid(fr_lookup_vid), .fr_done(fr_done),
    .fr_drop(fr_drop), .fr_ports(fr_ports), .fr_auth_en(fr_auth_en),
    .irq_almost_full(irq_almost_full), .irq_write_fail(irq_write_fail),
    .irq_learn_fail(irq_learn_fail));

  mlt_far_model far_u (.vid(fr_lookup_vid), .da(fr_da), .member(member), .st_hit(st_hit),
    .st_ports(st_ports));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is registered at the strobe edge and holds, so sample just after
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // Start a host operation and poll control bit b until it reads lv
  task automatic host_op(input logic [31:0] ctl, input int b, input logic lv);
    int n;
    n = 0;
    wr(mlt_pkg::ACC_OFS, ctl);
    rd(mlt_pkg::ACC_OFS);
    while (rv[b] !== lv && n < 50) begin
      rd(mlt_pkg::ACC_OFS);
      n++;
    end
  endtask

  task automatic frame(input logic tg, input logic [11:0] vid, input logic [47:0] sa);
    int n;
    n = 0;
    @(posedge clk);
    fr_tagged <= tg;
    fr_vid <= vid;
    fr_sa <= sa;
    fr_req <= 1'b1;
    @(posedge clk);
    fr_req <= 1'b0;
    #1;
    while (fr_done !== 1'b1 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("fr_done", {31'h0, fr_done}, 32'h1);
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog: the run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end

  // Main sequence; frames wait out the table sweep after reset
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(P_ST);
    chk("state_rst", rv, 32'h6);
    rd(P_PTR);
    chk("ptr_rst", rv, 32'h0);
    wr(P_CTL, 32'hFF);
    rd(P_CTL);
    chk("ctl_rw", rv, 32'hFA);
    wr(P_PTR, 32'h3);
    wr(P_ST, 32'h1);
    rd(P_ST);
    chk("state_i3", rv, 32'h1);
    wr(P_PTR, 32'h0);
    rd(P_ST);
    chk("state_i0", rv, 32'h6);
    wr(P_CTL, 32'h00);
    repeat (4100) @(posedge clk);
    frame(1'b1, 12'h000, 48'h0200_0000_1001);
    chk("vid_std", fr_lookup_vid, 32'h00A);
    chk("drop_none", fr_drop, 32'h0);
    chk("flood", fr_ports, 32'h3E);
    chk("auth_off", fr_auth_en, 32'h0);
    wr(P_CTL, 32'h80);
    frame(1'b1, 12'h000, 48'h0200_0000_1002);
    chk("vid_null", fr_lookup_vid, 32'h000);
    wr(P_CTL, 32'h20);
    frame(1'b1, 12'h005, 48'h0200_0000_1003);
    chk("non_def_vid", fr_drop, 32'h1);
    wr(P_CTL, 32'h40);
    frame(1'b1, 12'h005, 48'h0200_0000_1004);
    chk("ingr_drop", fr_drop, 32'h1);
    frame(1'b1, 12'h007, 48'h0200_0000_1005);
    chk("ingr_pass", fr_drop, 32'h0);
    wr(P_CTL, 32'h18);
    @(posedge clk);
    self_filt_en <= 1'b1;
    frame(1'b0, 12'h000, switch_mac);
    chk("self_drop", fr_drop, 32'h1);
    chk("auth_on", fr_auth_en, 32'h1);
    @(posedge clk);
    self_filt_en <= 1'b0;
    fr_da <= 48'h0200_0000_0BAD;
    frame(1'b0, 12'h000, switch_mac);
    chk("self_off", fr_drop, 32'h0);
    chk("static_da", fr_ports, 32'h0C);
    wr(P_ST, 32'h4);
    frame(1'b0, 12'h000, 48'h0200_0000_1006);
    chk("rx_off", fr_drop, 32'h1);
    wr(P_ST, 32'h6);
    // Port 3 transmit off: static result loses that port
    wr({4'h3, mlt_pkg::PORT_ST_OFS}, 32'h2);
    frame(1'b0, 12'h000, 48'h0200_0000_1007);
    chk("tx_off", fr_ports, 32'h08);
    // Hashed read of an absent key, then write and read it back
    wr(mlt_pkg::KEY_HI_OFS, 32'h0001_0200);
    wr(mlt_pkg::KEY_LO_OFS, 32'h0000_7777);
    host_op(32'h82, 7, 1'b0);
    chk("rd_miss", rv[7:5], 32'h1);
    for (int i = 0; i < 4; i++) begin
      rd(mlt_pkg::ENT1_OFS + 16'(4 * i));
      chk("ent_zero", rv, 32'h0);
    end
    wr(mlt_pkg::ENT1_OFS, 32'h0);
    wr(mlt_pkg::ENT2_OFS, 32'h5);
    wr(mlt_pkg::ENT3_OFS, 32'h0001_0200);
    wr(mlt_pkg::ENT4_OFS, 32'h0000_7777);
    host_op(32'h81, 7, 1'b0);
    chk("wr_done", rv[7], 32'h0);
    host_op(32'h82, 7, 1'b0);
    chk("rd_hit", rv[7:5], 32'h3);
    rd(mlt_pkg::ENT1_OFS);
    chk("ent1", rv, 32'h8000_0000);
    rd(mlt_pkg::ENT2_OFS);
    chk("ent2", rv, 32'h5);
    rd(mlt_pkg::ENT4_OFS);
    chk("ent4", rv, 32'h7777);
    // Filter group mixed into the hash moves the same key to an empty bucket
    @(posedge clk);
    hash_use_group <= 1'b1;
    host_op(32'h82, 7, 1'b0);
    chk("group_hash", rv[7:5], 32'h1);
    @(posedge clk);
    hash_use_group <= 1'b0;
    host_op(32'h83, 6, 1'b1);
    chk("srch_hit", rv[7:5], 32'h7);
    wr(mlt_pkg::ACC_OFS, 32'h0);
    // Fill bucket 0x368 with statics: third warns, fifth fails, then learning fails
    wr(mlt_pkg::KEY_LO_OFS, 32'h0000_0DA1);
    host_op(32'h85, 7, 1'b0);
    wr(mlt_pkg::KEY_HI_OFS, 32'h0002_0200);
    wr(mlt_pkg::KEY_LO_OFS, 32'h0000_7777);
    host_op(32'h81, 7, 1'b0);
    rd(mlt_pkg::EIDX0_OFS);
    chk("af_addr", rv, 32'h0000_0DA2);
    chk("af_irq", irq_seen, 32'h1);
    wr(mlt_pkg::KEY_LO_OFS, 32'h0000_0DA3);
    host_op(32'h85, 7, 1'b0);
    wr(mlt_pkg::KEY_HI_OFS, 32'h0003_0200);
    wr(mlt_pkg::KEY_LO_OFS, 32'h0000_7777);
    host_op(32'h81, 7, 1'b0);
    rd(mlt_pkg::EIDX0_OFS);
    chk("wf_idx", rv, 32'h0000_0368);
    chk("wf_irq", irq_seen, 32'h3);
    frame(1'b0, 12'h000, 48'h0000_0000_0368);
    rd(mlt_pkg::EIDX1_OFS);
    chk("lf_idx", rv, 32'h0000_0368);
    chk("lf_irq", irq_seen, 32'h7);
    tally_and_finish;
  end
endmodule
`default_nettype wire
